// *** inc/mcu_sysregs_defines.vh ***
// mcu_sysregs_defines.vh: offsets, field positions, reset values and vectors of the core's
// system register bank and data-space map. assumes an 8-bit data path and 12-bit program counter.
`ifndef MCU_SYSREGS_DEFINES_VH
`define MCU_SYSREGS_DEFINES_VH

// ----------------------------------------------------------------------------
// program space
// ----------------------------------------------------------------------------
`define PC_W                12
`define STACK_DEPTH         8
`define RESET_VECTOR        12'h000
`define IRQ_VECTOR          12'h004

// ----------------------------------------------------------------------------
// data space map
// ----------------------------------------------------------------------------
`define DADDR_W             9
`define SYS_LAST            9'h007
`define PERIPH_LAST         9'h07f
`define SRAM_FIRST          9'h080
`define SRAM_LAST           9'h17f
`define SRAM_DEPTH          256

// ----------------------------------------------------------------------------
// system register offsets
// ----------------------------------------------------------------------------
`define OFS_INDIRECT_PORT_0     9'h000
`define OFS_INDIRECT_PORT_1     9'h001
`define OFS_INDIRECT_POINTER_0  9'h002
`define OFS_INDIRECT_POINTER_1  9'h003
`define OFS_ALU_RESET_FLAGS     9'h004
`define OFS_ACCUMULATOR         9'h005
`define OFS_INTERRUPT_FLAGS_A   9'h006
`define OFS_INTERRUPT_ENABLES_A 9'h007
`define OFS_INTERRUPT_FLAGS_B   9'h016
`define OFS_INTERRUPT_ENABLES_B 9'h017

// peripheral registers reset on external reset only
`define OFS_WATCHDOG_CONTROL    9'h00d
`define OFS_PORT_FIRST          9'h020
`define OFS_PORT_LAST           9'h02b
`define OFS_SERIAL_IF_CONTROL   9'h057
`define OFS_SERIAL_IF_STATE     9'h058
`define OFS_SERIAL_IF_ADDRESS   9'h059
`define OFS_SERIAL_IF_BUFFER    9'h05a
`define OFS_PORT2_OUTPUT_CONFIG 9'h037

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define ST_POINTER1_PAGE    7
`define ST_POINTER0_PAGE    6
`define ST_SLEEP_ENTERED    4
`define ST_WATCHDOG_TIMEOUT 3
`define ST_NIBBLE_CARRY     2
`define ST_CARRY            1
`define ST_ZERO             0
`define ST_IMPL_MASK        8'hdf
`define ST_EXT_RESET_MASK   8'h27
`define ST_SW_WRITE_MASK    8'hc7

// ----------------------------------------------------------------------------
// interrupt fields and reset values
// ----------------------------------------------------------------------------
`define IEA_GLOBAL          7
`define IRQA_MASK           8'h1f
`define IEA_MASK            8'h9f
`define IRQB_MASK           8'h07
`define IRQ_RESET           8'h00
`define REG_RESET           8'h00
`define SERIAL_CTRL_RESET   8'h10
`define SERIAL_CTRL_MASK    8'hf0
`define SERIAL_STATE_MASK   8'h3d
`define PORT2_OC_RESET      8'h18
`define PORT2_OC_MASK       8'h18

`endif

// *** hw/return_stack.v ***
// return_stack.v: circular hardware stack of program counter values.
// assumes the core never pushes and pops in the same cycle; overflow wraps silently.
`timescale 1ns/1ps
`include "mcu_sysregs_defines.vh"

module return_stack #(
    parameter DEPTH = `STACK_DEPTH,
    parameter WIDTH = `PC_W
) (
    input  wire             i_clk,
    input  wire             i_rst,
    input  wire             i_push,
    input  wire             i_pop,
    input  wire [WIDTH-1:0] i_data,
    output wire [WIDTH-1:0] o_top
);
    reg [WIDTH-1:0] entry [0:DEPTH-1];
    reg [2:0]       sp;
    wire [2:0]      sp_dec = sp - 3'h1;

    // ------------------------------------------------------------------------
    // storage: like the original core, overflow overwrites the oldest entry
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_rst) begin
            sp <= 3'h0;
        end else if (i_push) begin
            entry[sp] <= i_data;
            sp        <= sp + 3'h1;
        end else if (i_pop) begin
            sp <= sp_dec;
        end
    end

    assign o_top = entry[sp_dec];
endmodule // return_stack

// *** hw/mcu_sysregs.v ***
// mcu_sysregs.v: program counter, return stack, data-space decode, system registers,
// general sram and the external-reset-only peripheral registers of an 8-bit core.
// assumes the execute logic gives one access per cycle on i_addr, reads combinationally
// through the registered o_rdata the next cycle, and drives one-cycle control pulses.
`timescale 1ns/1ps
`include "mcu_sysregs_defines.vh"

// Behaviour
// - 12-bit program counter addresses 4k words of 16-bit program space
// - eight-entry, 12-bit hardware return stack saves pc on calls and interrupts
// - start-up or program reset loads pc with reset vector zero
// - any interrupt service start loads pc with shared vector four
// - data addresses 0x00-0x07 decode to the system special registers
// - data addresses 0x08-0x7f decode to peripheral registers
// - data addresses 0x80-0x17f map to 256 bytes of sram, 384 total
// - indirect ports 0 and 1 access memory at pointer 0 and 1
// - status resets to 00000uuu externally; watchdog reset only sets bit 3
// - external reset clears watchdog, port and serial address/buffer regs; watchdog keeps them
// - bits marked u keep their value across reset
// - accumulator 0x05 kept at reset; interrupt regs 0x06/0x07 and 0x16/0x17 cleared at reset
// - interrupt bit layout: five sources a, global enable bit 7, three sources b
// - status bits 7 and 6 page pointers 1 and 0 into 0x1xx
// - watchdog timeout sets bit 3, software zero clears; sleep sets bit 4
module mcu_sysregs #(
    parameter SRAM_DEPTH = `SRAM_DEPTH
) (
    input  wire                i_clk,
    input  wire                i_rst,
    input  wire                i_wdt_reset,
    input  wire                i_wdt_timeout,
    input  wire                i_sleep,
    input  wire                i_pc_step,
    input  wire                i_pc_load,
    input  wire [`PC_W-1:0]    i_pc_target,
    input  wire                i_call,
    input  wire                i_return,
    input  wire                i_irq_take,
    input  wire [4:0]          i_irq_a_set,
    input  wire [2:0]          i_irq_b_set,
    input  wire [2:0]          i_alu_flags_we,
    input  wire [2:0]          i_alu_flags,
    input  wire [`DADDR_W-1:0] i_addr,
    input  wire                i_rd,
    input  wire                i_wr,
    input  wire [7:0]          i_wdata,
    output reg  [`PC_W-1:0]    o_pc,
    output reg  [7:0]          o_rdata,
    output reg                 o_periph_sel,
    output reg                 o_irq_pending,
    output reg  [7:0]          o_accumulator,
    output reg  [7:0]          o_status
);
    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    reg [7:0] sram [0:SRAM_DEPTH-1];
    reg [7:0] pointer_0;
    reg [7:0] pointer_1;
    reg [7:0] status;
    reg [7:0] accumulator;
    reg [7:0] irq_flags_a;
    reg [7:0] irq_enables_a;
    reg [7:0] irq_flags_b;
    reg [7:0] irq_enables_b;
    reg [7:0] watchdog_control;
    reg [7:0] port_reg [0:11];
    reg [7:0] serial_if_control;
    reg [7:0] serial_if_state;
    reg [7:0] serial_if_address;
    reg [7:0] serial_if_buffer;
    reg [7:0] port2_output_config;
    reg [`PC_W-1:0] pc;

    // ------------------------------------------------------------------------
    // indirect resolution: page bit extends the 8-bit pointer to 9 bits
    // ------------------------------------------------------------------------
    wire [`DADDR_W-1:0] ind_addr_0 = {status[`ST_POINTER0_PAGE], pointer_0};
    wire [`DADDR_W-1:0] ind_addr_1 = {status[`ST_POINTER1_PAGE], pointer_1};
    reg  [`DADDR_W-1:0] eff_addr;

    always @* begin
        if (i_addr == `OFS_INDIRECT_PORT_0) begin
            eff_addr = ind_addr_0;
        end else if (i_addr == `OFS_INDIRECT_PORT_1) begin
            eff_addr = ind_addr_1;
        end else begin
            eff_addr = i_addr;
        end
    end

    // an indirect port pointing at another indirect port reads zero, writes nothing:
    // avoids a combinational loop through the decode
    wire ind_self = (eff_addr <= `OFS_INDIRECT_PORT_1);
    wire in_sys    = (eff_addr <= `SYS_LAST) && !ind_self;
    wire in_periph = (eff_addr > `SYS_LAST) && (eff_addr <= `PERIPH_LAST);
    wire in_sram   = (eff_addr >= `SRAM_FIRST) && (eff_addr <= `SRAM_LAST);
    wire [7:0] sram_idx = eff_addr[7:0] - 8'h80;
    wire       in_port  = (eff_addr >= `OFS_PORT_FIRST) && (eff_addr <= `OFS_PORT_LAST);
    wire [3:0] port_idx = eff_addr[3:0] ^ 4'h0;
    wire wr_en = i_wr;

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        if (in_sram) begin
            next_rdata = sram[sram_idx];
        end else if (in_port) begin
            next_rdata = port_reg[port_idx[3:0] - 4'h0];
        end else begin
            case (eff_addr)
                `OFS_INDIRECT_POINTER_0:  next_rdata = pointer_0;
                `OFS_INDIRECT_POINTER_1:  next_rdata = pointer_1;
                `OFS_ALU_RESET_FLAGS:     next_rdata = status & `ST_IMPL_MASK;
                `OFS_ACCUMULATOR:         next_rdata = accumulator;
                `OFS_INTERRUPT_FLAGS_A:   next_rdata = irq_flags_a & `IRQA_MASK;
                `OFS_INTERRUPT_ENABLES_A: next_rdata = irq_enables_a & `IEA_MASK;
                `OFS_INTERRUPT_FLAGS_B:   next_rdata = irq_flags_b & `IRQB_MASK;
                `OFS_INTERRUPT_ENABLES_B: next_rdata = irq_enables_b & `IRQB_MASK;
                `OFS_WATCHDOG_CONTROL:    next_rdata = watchdog_control;
                `OFS_SERIAL_IF_CONTROL:   next_rdata = serial_if_control;
                `OFS_SERIAL_IF_STATE:     next_rdata = serial_if_state;
                `OFS_SERIAL_IF_ADDRESS:   next_rdata = serial_if_address;
                `OFS_SERIAL_IF_BUFFER:    next_rdata = serial_if_buffer;
                `OFS_PORT2_OUTPUT_CONFIG: next_rdata = port2_output_config;
                default:                  next_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // sram
    // ------------------------------------------------------------------------
    // no reset: contents are unknown at power-up and software sets what it uses
    always @(posedge i_clk) begin
        if (wr_en && in_sram) begin
            sram[sram_idx] <= i_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // pointers and accumulator: unknown at reset, so left unchanged
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (wr_en && in_sys && eff_addr == `OFS_INDIRECT_POINTER_0) begin
            pointer_0 <= i_wdata;
        end
        if (wr_en && in_sys && eff_addr == `OFS_INDIRECT_POINTER_1) begin
            pointer_1 <= i_wdata;
        end
        if (wr_en && in_sys && eff_addr == `OFS_ACCUMULATOR) begin
            accumulator <= i_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // status register
    // ------------------------------------------------------------------------
    wire status_wr = wr_en && in_sys && (eff_addr == `OFS_ALU_RESET_FLAGS);
    reg  [7:0] next_status;
    integer b;
    always @* begin
        next_status = status;
        if (status_wr) begin
            // sleep flag is not writable, timeout flag only cleared by writing zero, bit 5 unimplemented
            next_status = (status & ~`ST_SW_WRITE_MASK) | (i_wdata & `ST_SW_WRITE_MASK);
            if (!i_wdata[`ST_WATCHDOG_TIMEOUT]) begin
                next_status[`ST_WATCHDOG_TIMEOUT] = 1'b0;
            end
        end
        // the alu's own flag update wins over a software write of the same bits
        for (b = 0; b < 3; b = b + 1) begin
            if (i_alu_flags_we[b]) begin
                next_status[b] = i_alu_flags[b];
            end
        end
        if (i_sleep) begin
            next_status[`ST_SLEEP_ENTERED] = 1'b1;
        end
        if (i_wdt_timeout) begin
            next_status[`ST_WATCHDOG_TIMEOUT] = 1'b1;
        end
        next_status[5] = 1'b0;
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            // page, sleep, timeout and bit 5 cleared; bits 2..0 kept as unknown/unchanged
            // (so the alu flags are not a reliable zero after power-up)
            status <= status & `ST_EXT_RESET_MASK & `ST_IMPL_MASK;
        end else if (i_wdt_reset) begin
            status <= status | 8'h08;
        end else begin
            status <= next_status;
        end
    end

    // ------------------------------------------------------------------------
    // interrupt flags and enables; hardware set wins over software clear
    // ------------------------------------------------------------------------
    wire wr_fa = wr_en && in_sys && eff_addr == `OFS_INTERRUPT_FLAGS_A;
    wire wr_ea = wr_en && in_sys && eff_addr == `OFS_INTERRUPT_ENABLES_A;
    // 0x16/0x17 sit in the peripheral range, hence in_periph rather than in_sys
    wire wr_fb = wr_en && in_periph && eff_addr == `OFS_INTERRUPT_FLAGS_B;
    wire wr_eb = wr_en && in_periph && eff_addr == `OFS_INTERRUPT_ENABLES_B;
    wire [7:0] next_flags_a = ((wr_fa ? i_wdata : irq_flags_a) | {3'h0, i_irq_a_set}) & `IRQA_MASK;
    wire [7:0] next_flags_b = ((wr_fb ? i_wdata : irq_flags_b) | {5'h00, i_irq_b_set}) & `IRQB_MASK;
    reg  [7:0] next_enables_a;
    always @* begin
        next_enables_a = wr_ea ? (i_wdata & `IEA_MASK) : irq_enables_a;
        if (i_irq_take) begin
            next_enables_a[`IEA_GLOBAL] = 1'b0;
        end
    end
    wire irq_any = irq_enables_a[`IEA_GLOBAL]
                   && (|(irq_flags_a & irq_enables_a & `IRQA_MASK)
                       || |(irq_flags_b & irq_enables_b & `IRQB_MASK));

    always @(posedge i_clk) begin
        // both resets clear flags and enables, so no stale request survives a restart
        if (i_rst || i_wdt_reset) begin
            irq_flags_a   <= `IRQ_RESET;
            irq_enables_a <= `IRQ_RESET;
            irq_flags_b   <= `IRQ_RESET;
            irq_enables_b <= `IRQ_RESET;
        end else begin
            irq_flags_a   <= next_flags_a;
            irq_enables_a <= next_enables_a;
            irq_flags_b   <= next_flags_b;
            if (wr_eb) begin
                irq_enables_b <= i_wdata & `IRQB_MASK;
            end
        end
    end

    // ------------------------------------------------------------------------
    // peripheral registers that only external reset initialises
    // ------------------------------------------------------------------------
    genvar p;
    generate
        // ports 0x20-0x2b are one array indexed by the low address nibble
        for (p = 0; p < 12; p = p + 1) begin : g_port
            always @(posedge i_clk) begin
                if (i_rst) begin
                    port_reg[p] <= `REG_RESET;
                end else if (wr_en && in_port && port_idx == p) begin
                    port_reg[p] <= i_wdata;
                end
            end
        end
    endgenerate

    always @(posedge i_clk) begin
        if (i_rst) begin
            watchdog_control    <= `REG_RESET;
            serial_if_address   <= `REG_RESET;
            serial_if_buffer    <= `REG_RESET;
            serial_if_control   <= (serial_if_control & ~`SERIAL_CTRL_MASK) | `SERIAL_CTRL_RESET;
            serial_if_state     <= serial_if_state & ~`SERIAL_STATE_MASK;
            port2_output_config <= port2_output_config | `PORT2_OC_RESET;
        end else if (wr_en && in_periph) begin
            // watchdog reset falls here too and leaves these untouched
            case (eff_addr)
                `OFS_WATCHDOG_CONTROL:    watchdog_control    <= i_wdata;
                `OFS_SERIAL_IF_ADDRESS:   serial_if_address   <= i_wdata;
                `OFS_SERIAL_IF_BUFFER:    serial_if_buffer    <= i_wdata;
                `OFS_SERIAL_IF_CONTROL:   serial_if_control   <= i_wdata;
                `OFS_SERIAL_IF_STATE:     serial_if_state     <= i_wdata;
                `OFS_PORT2_OUTPUT_CONFIG: port2_output_config <= i_wdata;
                default:                  watchdog_control    <= watchdog_control;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // program counter and return stack
    // ------------------------------------------------------------------------
    wire [`PC_W-1:0] stack_top;
    wire [`PC_W-1:0] pc_next_seq = pc + 12'h001;
    return_stack #(
        .DEPTH (`STACK_DEPTH),
        .WIDTH (`PC_W)
    ) u_stack (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_push (i_call | i_irq_take),
        .i_pop  (i_return),
        .i_data (i_irq_take ? pc : pc_next_seq),
        .o_top  (stack_top)
    );

    reg [`PC_W-1:0] next_pc;
    always @* begin
        // interrupt entry wins over return, load, call and step in the same cycle; both resets win over it
        if (i_irq_take) begin
            next_pc = `IRQ_VECTOR;
        end else if (i_return) begin
            next_pc = stack_top;
        end else if (i_pc_load || i_call) begin
            next_pc = i_pc_target;
        end else if (i_pc_step) begin
            next_pc = pc_next_seq;
        end else begin
            next_pc = pc;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst || i_wdt_reset) begin
            pc <= `RESET_VECTOR;
        end else begin
            pc <= next_pc;
        end
    end

    // ------------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pc          <= `RESET_VECTOR;
            o_rdata       <= 8'h00;
            o_periph_sel  <= 1'b0;
            o_irq_pending <= 1'b0;
            o_accumulator <= 8'h00;
            o_status      <= 8'h00;
        end else begin
            // a watchdog reset restarts fetch, so the copy must follow pc to the reset vector
            o_pc          <= i_wdt_reset ? `RESET_VECTOR : next_pc;
            // zero outside reads, so a stale byte never looks like an answer
            o_rdata       <= i_rd ? next_rdata : 8'h00;
            o_periph_sel  <= (i_rd | i_wr) & in_periph & ~in_port;
            o_irq_pending <= irq_any;
            o_accumulator <= accumulator;
            o_status      <= status & `ST_IMPL_MASK;
        end
    end
endmodule // mcu_sysregs

// *** sim/mcu_sysregs_monitor.sv ***
// mcu_sysregs_monitor.sv: port-level checks on the system register bank.
// assumes one clock and the synchronous external reset; bound into mcu_sysregs.
`timescale 1ns/1ps

module mcu_sysregs_monitor #(
    parameter SRAM_DEPTH = 256
) (
    input wire        i_clk,
    input wire        i_rst,
    input wire        i_wdt_reset,
    input wire        i_wdt_timeout,
    input wire        i_sleep,
    input wire        i_pc_step,
    input wire        i_pc_load,
    input wire        i_call,
    input wire        i_return,
    input wire        i_irq_take,
    input wire [8:0]  i_addr,
    input wire        i_rd,
    input wire        i_wr,
    input wire [11:0] o_pc,
    input wire        o_periph_sel,
    input wire        o_irq_pending,
    input wire [7:0]  o_status
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire acc_any = i_rd || i_wr;
    // any of these moves pc too, so a plain step is judged only alone
    wire pc_other = i_pc_load || i_call || i_return || i_irq_take || i_wdt_reset;

    property p_rst;
        disable iff (1'b0) i_rst |=> o_pc == 12'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("pc not at reset vector");
    property p_step;
        i_pc_step && !pc_other |=> o_pc == $past(o_pc) + 12'h001;
    endproperty
    a_step: assert property (p_step) else $error("pc step wrong");
    property p_irq_vec;
        i_irq_take && !i_wdt_reset |=> o_pc == 12'h004;
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector wrong");
    property p_irq_mask;
        i_irq_take && !i_wr ##1 !i_wr |=> !o_irq_pending;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("global enable kept");
    property p_wdt_rst;
        i_wdt_reset |=> o_pc == 12'h000 ##1 o_status[3];
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset wrong");
    property p_wdt_to;
        i_wdt_timeout |-> ##2 o_status[3];
    endproperty
    a_wdt_to: assert property (p_wdt_to) else $error("timeout flag not set");
    property p_sleep;
        i_sleep |-> ##2 o_status[4];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flag not set");
    property p_bit5;
        o_status[5] == 1'b0;
    endproperty
    a_bit5: assert property (p_bit5) else $error("status bit5 not zero");
    property p_sys_dec;
        // the indirect ports may point anywhere, so they are left out
        acc_any && ((i_addr >= 9'h002 && i_addr <= 9'h007) || i_addr >= 9'h080) |=> !o_periph_sel;
    endproperty
    a_sys_dec: assert property (p_sys_dec) else $error("peripheral select wrong");
    property p_periph;
        acc_any && i_addr >= 9'h060 && i_addr <= 9'h07f |=> o_periph_sel;
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral select missing");
    c_irq: cover property (i_irq_take);
    c_wdt: cover property (i_wdt_reset);
    c_ind: cover property (i_rd && i_addr <= 9'h001);
endmodule // mcu_sysregs_monitor

bind mcu_sysregs mcu_sysregs_monitor #(.SRAM_DEPTH(SRAM_DEPTH)) u_mon (.*);

// *** sim/cpu_model.sv ***
// cpu_model.sv: stand-in for the core's execute side; one access or pulse at a time.
// assumes the bench calls its tasks; every change lands on the falling clock edge.
`timescale 1ns/1ps

module cpu_model (
    input  wire         i_clk,
    input  wire  [7:0]  i_rdata,
    output logic [8:0]  o_addr,
    output logic        o_rd,
    output logic        o_wr,
    output logic [7:0]  o_wdata,
    output logic [15:0] o_ctl
);
    // idle until the bench's first call
    initial begin
        o_addr = 9'h000;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_ctl = 16'h0000;
    end
    // held across one sampling edge; read data is taken a cycle later
    task acc(input logic w, input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge i_clk);
        o_addr = a;
        o_rd = !w;
        o_wr = w;
        o_wdata = d;
        @(negedge i_clk);
        q = i_rdata;
        o_rd = 1'b0;
        o_wr = 1'b0;
        // released data flips so a stale byte cannot pass
        o_wdata = ~d;
    endtask
    // one-cycle pulse, then an idle cycle so lagging copies settle
    task pulse(input logic [15:0] m);
        @(negedge i_clk);
        o_ctl = m;
        @(negedge i_clk);
        o_ctl = 16'h0000;
        @(negedge i_clk);
    endtask
endmodule // cpu_model

// *** sim/mcu_sysregs_tb.sv ***
// mcu_sysregs_tb.sv: self-checking bench for the system register bank.
// assumes a 250 MHz clock; cpu_model drives every access and ctl pulse; the bench drives the alu flag pulse.
`timescale 1ns/1ps

module mcu_sysregs_tb;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [8:0]  addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic [15:0] ctl;
    logic [7:0]  rdata;
    logic [11:0] pc;
    logic        periph_sel;
    logic        irq_pending;
    logic [7:0]  accu;
    logic [7:0]  status;
    logic [7:0]  q;
    logic [11:0] target = 12'h123;
    logic [2:0]  alu_we = 3'b000;
    logic [2:0]  alu_v = 3'b000;
    logic [8:0]  irq_regs [4] = '{9'h006, 9'h007, 9'h016, 9'h017};
    logic [8:0]  ext_regs [5] = '{9'h00d, 9'h020, 9'h02b, 9'h059, 9'h05a};
    int          n_fail = 0;
    int          compares = 0;

    initial begin
        forever #2 i_clk = ~i_clk;
    end

    cpu_model u_cpu (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr),
                     .o_wdata(wdata), .o_ctl(ctl));
    // bit map of ctl: step, load, call, return, take, timeout, sleep, watchdog reset, flags
    mcu_sysregs dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wdt_reset(ctl[7]), .i_wdt_timeout(ctl[5]),
        .i_sleep(ctl[6]), .i_pc_step(ctl[0]), .i_pc_load(ctl[1]), .i_pc_target(target),
        .i_call(ctl[2]), .i_return(ctl[3]), .i_irq_take(ctl[4]), .i_irq_a_set(ctl[12:8]),
        .i_irq_b_set(ctl[15:13]), .i_alu_flags_we(alu_we), .i_alu_flags(alu_v), .i_addr(addr),
        .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_pc(pc), .o_rdata(rdata), .o_periph_sel(periph_sel),
        .o_irq_pending(irq_pending), .o_accumulator(accu), .o_status(status));

    task chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task rd_chk(input logic [8:0] a, input logic [7:0] e);
        u_cpu.acc(1'b0, a, 8'h00, q);
        chk({4'h0, q}, {4'h0, e});
    endtask
    task wr_reg(input logic [8:0] a, input logic [7:0] d);
        u_cpu.acc(1'b1, a, d, q);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge i_clk);
        i_rst = 1'b0;
        chk(pc, 12'h000);
        chk({4'h0, status & 8'hd8}, 12'h000);
        foreach (irq_regs[i]) rd_chk(irq_regs[i], 8'h00);
        wr_reg(9'h110, 8'h5a);
        wr_reg(9'h004, 8'h40);
        wr_reg(9'h002, 8'h10);
        rd_chk(9'h000, 8'h5a);
        wr_reg(9'h003, 8'h90);
        wr_reg(9'h001, 8'ha5);
        rd_chk(9'h090, 8'ha5);
        wr_reg(9'h17f, 8'h3c);
        rd_chk(9'h17f, 8'h3c);
        wr_reg(9'h005, 8'h96);
        rd_chk(9'h005, 8'h96);
        chk({4'h0, accu}, 12'h096);
        wr_reg(9'h070, 8'h00);
        wr_reg(9'h016, 8'hff);
        rd_chk(9'h016, 8'h07);
        wr_reg(9'h007, 8'hff);
        rd_chk(9'h007, 8'h9f);
        u_cpu.pulse(16'h0100);
        chk({11'h000, irq_pending}, 12'h001);
        u_cpu.pulse(16'h0001);
        u_cpu.pulse(16'h0001);
        u_cpu.pulse(16'h0010);
        chk(pc, 12'h004);
        rd_chk(9'h007, 8'h1f);
        rd_chk(9'h006, 8'h01);
        u_cpu.pulse(16'h0008);
        chk(pc, 12'h002);
        wr_reg(9'h006, 8'h00);
        rd_chk(9'h006, 8'h00);
        // eight nested calls, then unwind: only the deepest entry holds the first return
        for (int i = 0; i < 8; i++) u_cpu.pulse(16'h0004);
        for (int i = 0; i < 8; i++) begin
            u_cpu.pulse(16'h0008);
            chk(pc, (i == 7) ? 12'h003 : 12'h124);
        end
        target = 12'hfff;
        u_cpu.pulse(16'h0002);
        chk(pc, 12'hfff);
        u_cpu.pulse(16'h0001);
        chk(pc, 12'h000);
        u_cpu.pulse(16'h0020);
        chk({11'h000, status[3]}, 12'h001);
        wr_reg(9'h004, 8'h00);
        alu_we = 3'b111;
        alu_v = 3'b101;
        @(negedge i_clk);
        alu_we = 3'b000;
        rd_chk(9'h004, 8'h05);
        // sleep and a step together, so the watchdog reset below has a pc to clear
        u_cpu.pulse(16'h0041);
        chk({10'h000, status[4:3]}, 12'h002);
        wr_reg(9'h00d, 8'h55);
        u_cpu.pulse(16'h0080);
        chk(pc, 12'h000);
        chk({11'h000, status[3]}, 12'h001);
        rd_chk(9'h00d, 8'h55);
        u_cpu.pulse(16'h8000);
        rd_chk(9'h016, 8'h04);
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        foreach (ext_regs[i]) rd_chk(ext_regs[i], 8'h00);
        chk({4'h0, status}, 12'h005);
        print_verdict;
    end

    initial begin
        #40000;
        n_fail++;
        print_verdict;
    end
endmodule // mcu_sysregs_tb
